// ### bench/srrs_far_model.sv
`timescale 1ns/1ps
module srrs_far_model #(
    parameter int HALF_C = 5,
    parameter int HALF_U = 4,
    parameter int LAG    = 3
) (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // requests from the bench
    input  wire logic cfg_run_i,
    input  wire logic user_run_i,
    input  wire logic done_req_i,
    // pins seen by the sequencer
    output logic      cfg_clk_o,
    output logic      user_clk_o,
    output logic      done_o
);
    int cc;
    int cu;
    int cd;

    // a stopped clock always finishes its high phase and rests low
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cc <= 0;
            cfg_clk_o <= 1'b0;
        end else if (cfg_run_i || cfg_clk_o) begin
            cc <= (cc == HALF_C - 1) ? 0 : cc + 1;
            if (cc == HALF_C - 1) cfg_clk_o <= ~cfg_clk_o;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cu <= 0;
            user_clk_o <= 1'b0;
        end else if (user_run_i || user_clk_o) begin
            cu <= (cu == HALF_U - 1) ? 0 : cu + 1;
            if (cu == HALF_U - 1) user_clk_o <= ~user_clk_o;
        end
    end

    // the rest of the chain finishes a few cycles late
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i || !done_req_i) begin
            cd <= 0;
            done_o <= 1'b0;
        end else if (cd == LAG) begin
            done_o <= 1'b1;
        end else begin
            cd <= cd + 1;
        end
    end
endmodule : srrs_far_model

// ### bench/startup_reset_release_sequencer_test.sv
`timescale 1ns/1ps
module startup_reset_release_sequencer_test;
    import srrs_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        clock_i, rst_i, cfg_clk_i, user_clk_i, done_input_i, global_set_reset_o;
    logic        length_count_met_i, done_align_count_met_i, cfg_run, usr_run, done_req;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [6:0]  bad [10] = '{7'h22, 7'h34, 7'h35, 7'h06, 7'h17, 7'h28, 7'h10, 7'h03, 7'h09, 7'h31};
    int          n_errors, samples_checked, n_cfg, n_usr;

    srrs_sequencer DUT (.clock_i, .rst_i, .cfg_clk_i, .user_clk_i, .done_input_i, .length_count_met_i,
        .done_align_count_met_i, .global_set_reset_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    srrs_far_model FAR (.clock_i, .rst_i, .cfg_run_i(cfg_run), .user_run_i(usr_run), .done_req_i(done_req),
        .cfg_clk_o(cfg_clk_i), .user_clk_o(user_clk_i), .done_o(done_input_i));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge cfg_clk_i) n_cfg++;
    always @(posedge user_clk_i) n_usr++;

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic summarize;
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic tmo(input string msg);
        chk(32'h0, 32'h1, msg);
        summarize();
    endtask : tmo

    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge clock_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        tmo("write hang");
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge clock_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                v = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        tmo("read hang");
    endtask : rd

    // ****************************************
    // one startup from reset to release
    // ****************************************
    task automatic run(input logic [6:0] ctl, input int n);
        logic dopt;
        logic usr;
        int   k;
        dopt = ctl[3:0] >= SRRS_REL_DONE;
        usr = ctl[SRRS_CLK_USER_BIT];
        rst_i <= 1'b1;
        length_count_met_i <= 1'b0;
        done_align_count_met_i <= 1'b0;
        done_req <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        wr(SRRS_ADDR_CTRL, {25'h0, ctl}, r);
        rd(SRRS_ADDR_CTRL, d, r);
        chk(d, {25'h0, ctl}, "ctrl readback");
        // the count of the other alignment must not start the sequence
        if (ctl[SRRS_ALIGN_BIT]) length_count_met_i <= 1'b1;
        else done_align_count_met_i <= 1'b1;
        // pin edges before the count is met must not count
        cfg_run <= 1'b1;
        usr_run <= usr;
        repeat (60) @(posedge clock_i);
        chk(global_set_reset_o, 1'b1, "early release");
        rd(SRRS_ADDR_STATUS, d, r);
        chk(d[SRRS_ST_STATE_LSB+1:SRRS_ST_STATE_LSB], 2'h0, "wrong count started");
        cfg_run <= 1'b0;
        usr_run <= 1'b0;
        repeat (12) @(posedge clock_i);
        if (ctl[SRRS_ALIGN_BIT]) done_align_count_met_i <= 1'b1;
        else length_count_met_i <= 1'b1;
        n_cfg = 0;
        if (usr || dopt) begin
            // user edges ahead of the first cfg edge must be ignored
            usr_run <= usr;
            repeat (24) @(posedge clock_i);
            usr_run <= 1'b0;
            repeat (8) @(posedge clock_i);
            cfg_run <= 1'b1;
            for (k = 0; k < 100 && n_cfg == 0; k++) @(posedge clock_i);
            if (n_cfg == 0) tmo("no cfg edge");
            cfg_run <= !dopt;
            repeat (8) @(posedge clock_i);
        end
        if (dopt) begin
            done_req <= 1'b1;
            repeat (12) @(posedge clock_i);
        end
        n_cfg = 0;
        n_usr = 0;
        if (usr) usr_run <= 1'b1;
        else cfg_run <= 1'b1;
        for (k = 0; k < 300 && global_set_reset_o !== 1'b0; k++) @(posedge clock_i);
        if (k == 300) tmo("no release");
        cfg_run <= 1'b0;
        usr_run <= 1'b0;
        chk(usr ? n_usr : n_cfg, n, "edges before release");
        repeat (30) @(posedge clock_i);
        chk(global_set_reset_o, 1'b0, "set-reset came back");
        rd(SRRS_ADDR_STATUS, d, r);
        chk(d[7:0], {dopt, 3'h0, 4'hC}, "status after release");
        wr(SRRS_ADDR_CTRL, 32'h01, r);
        rd(SRRS_ADDR_STATUS, d, r);
        chk(d[SRRS_ST_REJ_BIT], 1'b1, "late ctrl write");
    endtask : run

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_i, length_count_met_i, done_align_count_met_i, cfg_run, usr_run, done_req} = 6'h20;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(SRRS_ADDR_CTRL, d, r);
        chk(d, 32'h01, "ctrl reset value");
        rd(SRRS_ADDR_STATUS, d, r);
        chk(d, 32'h01, "status reset value");
        wr(4'h8, 32'h0, r);
        chk(r, SRRS_RESP_SLVERR, "unmapped write");
        rd(4'h8, d, r);
        chk(r, SRRS_RESP_SLVERR, "unmapped read resp");
        chk(d, 32'h0, "unmapped read data");
        foreach (bad[i]) begin
            wr(SRRS_ADDR_CTRL, {25'h0, bad[i]}, r);
            rd(SRRS_ADDR_CTRL, d, r);
            chk(d, 32'h01, "illegal setting kept");
            rd(SRRS_ADDR_STATUS, d, r);
            chk(d[SRRS_ST_REJ_BIT], 1'b1, "reject flag");
        end
        wr(SRRS_ADDR_CTRL, 32'h01, r);
        rd(SRRS_ADDR_STATUS, d, r);
        chk(d[SRRS_ST_REJ_BIT], 1'b0, "reject flag clear");
        s_axi_wstrb <= 4'hE;
        wr(SRRS_ADDR_CTRL, 32'h02, r);
        s_axi_wstrb <= 4'hF;
        rd(SRRS_ADDR_CTRL, d, r);
        chk(d, 32'h01, "ctrl written without low strobe");
        run(7'h00, 2);
        run(7'h01, 3);
        run(7'h02, 4);
        run(7'h41, 3);
        run(7'h13, 2);
        run(7'h14, 3);
        run(7'h15, 4);
        run(7'h20, 2);
        run(7'h21, 3);
        run(7'h26, 0);
        run(7'h27, 1);
        run(7'h33, 2);
        run(7'h36, 0);
        run(7'h37, 1);
        run(7'h38, 2);
        summarize();
    end
endmodule : startup_reset_release_sequencer_test

// ### rtl/srrs_pkg.sv
package srrs_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] SRRS_ADDR_CTRL    = 4'h0;
    localparam logic [3:0] SRRS_ADDR_STATUS  = 4'h4;
    localparam int         SRRS_SEL_LSB      = 0;
    localparam int         SRRS_CLK_USER_BIT = 4;
    localparam int         SRRS_SYNC_BIT     = 5;
    localparam int         SRRS_ALIGN_BIT    = 6;
    localparam int         SRRS_ST_GSR_BIT   = 0;
    localparam int         SRRS_ST_REJ_BIT   = 1;
    localparam int         SRRS_ST_STATE_LSB = 2;
    localparam int         SRRS_ST_CNT_LSB   = 4;
    localparam int         SRRS_ST_DONE_BIT  = 7;
    localparam logic [1:0] SRRS_RESP_OKAY    = 2'h0;
    localparam logic [1:0] SRRS_RESP_SLVERR  = 2'h2;

    // ****************************************
    // release events and sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        SRRS_REL_C2      = 4'h0,
        SRRS_REL_C3      = 4'h1,
        SRRS_REL_C4      = 4'h2,
        SRRS_REL_U2      = 4'h3,
        SRRS_REL_U3      = 4'h4,
        SRRS_REL_U4      = 4'h5,
        SRRS_REL_DONE    = 4'h6,
        SRRS_REL_DONE_P1 = 4'h7,
        SRRS_REL_DONE_P2 = 4'h8
    } srrs_rel_type;

    typedef enum logic [1:0] {
        SRRS_ST_CONFIG = 2'b00,
        SRRS_ST_C1WAIT = 2'b01,
        SRRS_ST_COUNT  = 2'b10,
        SRRS_ST_USER   = 2'b11
    } srrs_state_type;

    typedef struct packed {
        logic         align_done;
        logic         sync_to_done_in;
        logic         startup_clock_select;
        srrs_rel_type global_reset_release_select;
    } srrs_cfg_type;

    // defaults: cfg clock, no done sync, length alignment, third cfg edge
    localparam srrs_cfg_type SRRS_CFG_RESET = '{1'b0, 1'b0, 1'b0, SRRS_REL_C3};
    localparam int           SRRS_SYNC_DEPTH = 3;

endpackage : srrs_pkg

// ### rtl/srrs_sequencer.sv
`timescale 1ns/1ps
module srrs_sequencer
    import srrs_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // startup pins and configuration status
    input  wire logic        cfg_clk_i,
    input  wire logic        user_clk_i,
    input  wire logic        done_input_i,
    input  wire logic        length_count_met_i,
    input  wire logic        done_align_count_met_i,
    output logic             global_set_reset_o,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic rel_legal(input srrs_cfg_type c);
        logic ok;
        ok = 1'b0;
        unique case ({c.startup_clock_select, c.sync_to_done_in})
            2'b01: ok = c.global_reset_release_select inside {SRRS_REL_C2, SRRS_REL_C3,
                                                              SRRS_REL_DONE, SRRS_REL_DONE_P1};
            2'b00: ok = c.global_reset_release_select inside {SRRS_REL_C2, SRRS_REL_C3, SRRS_REL_C4};
            2'b11: ok = c.global_reset_release_select inside {SRRS_REL_U2, SRRS_REL_DONE,
                                                              SRRS_REL_DONE_P1, SRRS_REL_DONE_P2};
            2'b10: ok = c.global_reset_release_select inside {SRRS_REL_U2, SRRS_REL_U3, SRRS_REL_U4};
        endcase
        return ok;
    endfunction : rel_legal

    // number of counted edges that releases
    function automatic logic [2:0] rel_target(input srrs_rel_type s);
        logic [2:0] n;
        n = 3'h4;
        unique case (s)
            SRRS_REL_C2, SRRS_REL_U2, SRRS_REL_DONE_P2: n = 3'h2;
            SRRS_REL_C3, SRRS_REL_U3:                   n = 3'h3;
            SRRS_REL_DONE_P1, SRRS_REL_DONE:            n = 3'h1;
            default:                                    n = 3'h4;
        endcase
        return n;
    endfunction : rel_target

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0]     sy1_q, sy2_q, sy3_q, lvl_q, rise;
    logic           cfg_rise, usr_rise, done_hi, start_rise;
    srrs_cfg_type   cfg_q;
    srrs_state_type state_q;
    logic [2:0]     cnt_q;
    logic           done_seen_q;
    logic           reject_q;
    logic           count_met;
    logic           is_c, is_u, is_dp;

    assign cfg_rise   = rise[0];
    assign usr_rise   = rise[1];
    assign done_hi    = lvl_q[2];
    assign start_rise = cfg_q.startup_clock_select ? usr_rise : cfg_rise;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
            sy3_q <= 3'h0;
        end else begin
            sy1_q <= {done_input_i, user_clk_i, cfg_clk_i};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    // a level counts only once the 2nd and 3rd stage agree
    for (genvar g = 0; g < SRRS_SYNC_DEPTH; g++) begin : g_filt
        assign rise[g] = sy2_q[g] & sy3_q[g] & ~lvl_q[g];
        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                lvl_q[g] <= 1'b0;
            end else if (sy2_q[g] == sy3_q[g]) begin
                lvl_q[g] <= sy3_q[g];
            end
        end
    end

    // ****************************************
    // release sequencer
    // ****************************************
    assign count_met = cfg_q.align_done ? done_align_count_met_i : length_count_met_i;
    assign is_c  = cfg_q.global_reset_release_select inside {SRRS_REL_C2, SRRS_REL_C3, SRRS_REL_C4};
    assign is_u  = cfg_q.global_reset_release_select inside {SRRS_REL_U2, SRRS_REL_U3, SRRS_REL_U4};
    assign is_dp = cfg_q.global_reset_release_select inside {SRRS_REL_DONE_P1, SRRS_REL_DONE_P2};

    logic       step;
    logic [2:0] cnt_next;
    logic       release_now;

    always_comb begin
        step = 1'b0;
        if (is_c) begin
            step = cfg_rise;
        end else if (is_u) begin
            step = usr_rise;
        end else if (is_dp) begin
            step = done_seen_q & start_rise;
        end
        cnt_next = cnt_q + 3'h1;
        release_now = 1'b0;
        if (state_q == SRRS_ST_COUNT) begin
            if (cfg_q.global_reset_release_select == SRRS_REL_DONE) begin
                release_now = done_hi;
            end else begin
                release_now = step && (cnt_next == rel_target(cfg_q.global_reset_release_select));
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= SRRS_ST_CONFIG;
        end else begin
            unique case (state_q)
                SRRS_ST_CONFIG: if (count_met) begin
                    state_q <= is_u ? SRRS_ST_C1WAIT : SRRS_ST_COUNT;
                end
                // user edges count only after the first cfg edge
                SRRS_ST_C1WAIT: if (cfg_rise) begin
                    state_q <= SRRS_ST_COUNT;
                end
                SRRS_ST_COUNT: if (release_now) begin
                    state_q <= SRRS_ST_USER;
                end
                SRRS_ST_USER: state_q <= SRRS_ST_USER;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 3'h0;
        end else if (state_q != SRRS_ST_COUNT) begin
            cnt_q <= 3'h0;
        end else if (step) begin
            cnt_q <= cnt_next;
        end
    end

    // done sync: edges after done rises; an edge in the same cycle is not counted
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            done_seen_q <= 1'b0;
        end else if (state_q == SRRS_ST_CONFIG) begin
            done_seen_q <= 1'b0;
        end else if (done_hi && cfg_q.sync_to_done_in) begin
            done_seen_q <= 1'b1;
        end
    end

    // held from reset (configuration) until release, never raised again
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            global_set_reset_o <= 1'b1;
        end else if (release_now) begin
            global_set_reset_o <= 1'b0;
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic aw_got_q, w_got_q, wstrb_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        wr_fire;
    srrs_cfg_type wr_cfg;

    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign wr_cfg  = srrs_cfg_type'(wdata_q[SRRS_ALIGN_BIT:SRRS_SEL_LSB]);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            wstrb_q  <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q  <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SRRS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == SRRS_ADDR_CTRL || awaddr_q == SRRS_ADDR_STATUS)
                            ? SRRS_RESP_OKAY : SRRS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // settings freeze once the count is met; illegal combinations never land
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q    <= SRRS_CFG_RESET;
            reject_q <= 1'b0;
        end else if (wr_fire && awaddr_q == SRRS_ADDR_CTRL && wstrb_q) begin
            if (rel_legal(wr_cfg) && state_q == SRRS_ST_CONFIG) begin
                cfg_q    <= wr_cfg;
                reject_q <= 1'b0;
            end else begin
                reject_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= SRRS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= SRRS_RESP_OKAY;
            s_axi_rdata  <= 32'h0;
            if (s_axi_araddr == SRRS_ADDR_CTRL) begin
                s_axi_rdata[SRRS_ALIGN_BIT:SRRS_SEL_LSB] <= cfg_q;
            end else if (s_axi_araddr == SRRS_ADDR_STATUS) begin
                s_axi_rdata[SRRS_ST_GSR_BIT]                      <= global_set_reset_o;
                s_axi_rdata[SRRS_ST_REJ_BIT]                      <= reject_q;
                s_axi_rdata[SRRS_ST_STATE_LSB+1:SRRS_ST_STATE_LSB] <= state_q;
                s_axi_rdata[SRRS_ST_CNT_LSB+2:SRRS_ST_CNT_LSB]     <= cnt_q;
                s_axi_rdata[SRRS_ST_DONE_BIT]                     <= done_seen_q;
            end else begin
                s_axi_rresp <= SRRS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_gsr_held_config: assert property (state_q != SRRS_ST_USER |-> global_set_reset_o)
        else $error("set-reset dropped before release");
    a_gsr_stays_low: assert property (!global_set_reset_o |=> !global_set_reset_o && state_q == SRRS_ST_USER)
        else $error("set-reset raised again after release");
    a_release_legal_cfg: assert property ($fell(global_set_reset_o) |-> rel_legal(cfg_q))
        else $error("release with illegal setting");
    a_cfg_edge_count: assert property ($fell(global_set_reset_o) && is_c |->
        $past(cfg_rise) && ($past(cnt_q) + 3'h1 == rel_target(cfg_q.global_reset_release_select)))
        else $error("cfg edge release on wrong edge");
    a_user_edge_count: assert property ($fell(global_set_reset_o) && is_u |->
        $past(usr_rise) && ($past(cnt_q) + 3'h1 == rel_target(cfg_q.global_reset_release_select)))
        else $error("user edge release on wrong edge");
    a_done_rise_now: assert property (state_q == SRRS_ST_COUNT && done_hi
        && cfg_q.global_reset_release_select == SRRS_REL_DONE |=> !global_set_reset_o)
        else $error("done rise did not release at once");
    a_done_plus_edge: assert property ($fell(global_set_reset_o) && is_dp |->
        $past(done_seen_q) && $past(start_rise))
        else $error("done-plus release without startup edge after done");
    a_cclk_sync_set: assert property (wr_fire && awaddr_q == SRRS_ADDR_CTRL && wstrb_q && wr_cfg.sync_to_done_in
        && !wr_cfg.startup_clock_select && !(wr_cfg.global_reset_release_select inside {SRRS_REL_C2, SRRS_REL_C3,
        SRRS_REL_DONE, SRRS_REL_DONE_P1}) |=> $stable(cfg_q) && reject_q)
        else $error("illegal cfg-clock sync setting taken");
    a_uclk_sync_set: assert property (wr_fire && awaddr_q == SRRS_ADDR_CTRL && wstrb_q && wr_cfg.sync_to_done_in
        && wr_cfg.startup_clock_select && !(wr_cfg.global_reset_release_select inside {SRRS_REL_U2, SRRS_REL_DONE,
        SRRS_REL_DONE_P1, SRRS_REL_DONE_P2}) |=> $stable(cfg_q) && reject_q)
        else $error("illegal user-clock sync setting taken");
    a_align_start_seq: assert property (state_q == SRRS_ST_CONFIG && count_met |=> state_q != SRRS_ST_CONFIG)
        else $error("selected count met did not start sequence");

    c_cfg_release:  cover property ($fell(global_set_reset_o) && is_c);
    c_user_release: cover property ($fell(global_set_reset_o) && is_u);
    c_done_release: cover property ($fell(global_set_reset_o) && is_dp);
    c_reject_write: cover property ($rose(reject_q));

endmodule : srrs_sequencer
